/* rtl/lioc_pkg.sv */
// Constants, codes and tables of the indicator output control block
package lioc_pkg;
	// Clock and time base
	localparam int LIOC_CLK_PERIOD_NS = 40;
	localparam int LIOC_MS_NS = 1000000;
	localparam int LIOC_MS_CYCLES = LIOC_MS_NS / LIOC_CLK_PERIOD_NS;
	// Register byte offsets
	localparam logic [7:0] LIOC_OFS_FUNC = 8'h00;
	localparam logic [7:0] LIOC_OFS_POL = 8'h04;
	localparam logic [7:0] LIOC_OFS_TIM = 8'h08;
	localparam logic [7:0] LIOC_OFS_STAT = 8'h0C;
	// Reset values
	localparam logic [15:0] LIOC_FUNC_RST = 16'h0010;
	localparam logic [15:0] LIOC_POL_RST = 16'h0000;
	localparam logic [15:0] LIOC_TIM_RST = 16'h4100;
	// Field positions
	localparam int LIOC_FN2_LSB = 8;
	localparam int LIOC_FN1_LSB = 4;
	localparam int LIOC_FN0_LSB = 0;
	localparam int LIOC_MIX1_LSB = 12;
	localparam int LIOC_MIX0_LSB = 8;
	localparam int LIOC_STR_LSB = 12;
	localparam int LIOC_BLK_LSB = 8;
	localparam logic [3:0] LIOC_MIX_FULL = 4'h8;
	localparam logic [1:0] LIOC_HTRANS_NONSEQ = 2'h2;
	// Function field codes
	typedef enum logic [3:0] {
		LIOC_FN_SEL0 = 4'b0000, LIOC_FN_SEL1 = 4'b0001, LIOC_FN_SEL2 = 4'b0010, LIOC_FN_SEL3 = 4'b0011,
		LIOC_FN_SEL4 = 4'b0100, LIOC_FN_SEL5 = 4'b0101, LIOC_FN_SEL6 = 4'b0110, LIOC_FN_SEL7 = 4'b0111,
		LIOC_FN_OFF = 4'b1000, LIOC_FN_ON = 4'b1001, LIOC_FN_HIZ = 4'b1010, LIOC_FN_BLINK = 4'b1011,
		LIOC_FN_PAIR1 = 4'b1100, LIOC_FN_PAIR2 = 4'b1101, LIOC_FN_PAIR3 = 4'b1110, LIOC_FN_PAIR4 = 4'b1111
	} lioc_func_e;
	// Link speed codes
	typedef enum logic [1:0] {
		LIOC_SPD_10 = 2'b00, LIOC_SPD_100 = 2'b01, LIOC_SPD_1000 = 2'b10
	} lioc_speed_e;
	// Minimum stretch length in ms per stretch code
	localparam logic [10:0] LIOC_STRETCH_MS [8] = '{11'd0, 11'd21, 11'd42, 11'd84, 11'd170, 11'd340,
		11'd670, 11'd1300};
	// Blink half period in ms per rate code; reserved codes take the slowest rate
	localparam logic [9:0] LIOC_BLINK_MS [8] = '{10'd42, 10'd84, 10'd170, 10'd340, 10'd670, 10'd670,
		10'd670, 10'd670};
endpackage

/* rtl/lioc_indicator_ctrl.sv */
// Indicator output control: register slave, stretch, blink, mix and polarity stages
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
module lioc_indicator_ctrl import lioc_pkg::*; #(
	parameter int MS_CYCLES = LIOC_MS_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic link_up,
	input wire logic [1:0] link_speed,
	input wire logic fiber_link,
	input wire logic full_duplex,
	input wire logic collision,
	input wire logic tx_activity,
	input wire logic rx_activity,
	input wire logic config_done,
	input wire logic indicator_pin_zero_in,
	output logic indicator_pin_zero_out,
	output logic indicator_pin_zero_oe,
	input wire logic indicator_pin_one_in,
	output logic indicator_pin_one_out,
	output logic indicator_pin_one_oe,
	output logic indicator_pin_two_out,
	output logic indicator_pin_two_oe
);
	localparam int MSW = $clog2(MS_CYCLES);

	logic [15:0] func_q;
	logic [15:0] pol_q;
	logic [15:0] tim_q;
	logic wr_pend_q;
	logic [7:0] addr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] strap_q;
	logic [MSW-1:0] ms_cnt_q;
	logic ms_tick;
	logic [9:0] blink_ms_q;
	logic blink_q;
	logic [2:0] mix_ph_q;
	logic [2:0] raw_act;
	logic [2:0] str_act;
	logic [2:0] stretch_code;
	logic [2:0] blink_code;
	logic [2:0] lit_d;
	logic [2:0] hiz_d;
	logic [2:0] lit_q;
	logic [2:0] pin_out_q;
	logic [2:0] pin_oe_q;
	logic paired;
	logic unit_on;
	logic [3:0] mix0;
	logic [3:0] mix1;

	assign stretch_code = tim_q[LIOC_STR_LSB +: 3];
	assign blink_code = tim_q[LIOC_BLK_LSB +: 3];
	assign mix0 = pol_q[LIOC_MIX0_LSB +: 4];
	assign mix1 = pol_q[LIOC_MIX1_LSB +: 4];
	assign paired = (func_q[3:2] == 2'b11);

	// Zero wait state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans == LIOC_HTRANS_NONSEQ && hwrite;
			addr_q <= haddr[7:0];
		end
	end

	// Read mux, unmapped offsets read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (haddr[7:0])
			LIOC_OFS_FUNC: rdata_d = {16'h0000, func_q};
			LIOC_OFS_POL: rdata_d = {16'h0000, pol_q};
			LIOC_OFS_TIM: rdata_d = {16'h0000, tim_q};
			LIOC_OFS_STAT: rdata_d = {22'h000000, lit_q, blink_q, str_act, strap_q, config_done};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data is loaded at the address phase and stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (hready && hsel && htrans == LIOC_HTRANS_NONSEQ && !hwrite) begin
			rdata_q <= rdata_d;
		end
	end

	// Register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_q <= LIOC_FUNC_RST;
			pol_q <= LIOC_POL_RST;
			tim_q <= LIOC_TIM_RST;
		end else if (wr_pend_q) begin
			case (addr_q)
				LIOC_OFS_FUNC: func_q <= hwdata[15:0];
				LIOC_OFS_POL: pol_q <= hwdata[15:0];
				LIOC_OFS_TIM: tim_q <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// Strap levels follow the pins until configuration is over, then hold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_q <= 2'b00;
		end else if (!config_done) begin
			strap_q <= {indicator_pin_one_in, indicator_pin_zero_in};
		end
	end

	// Millisecond time base
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_cnt_q <= '0;
		end else if (ms_tick) begin
			ms_cnt_q <= '0;
		end else begin
			ms_cnt_q <= ms_cnt_q + 1'b1;
		end
	end
	assign ms_tick = (ms_cnt_q == MSW'(MS_CYCLES - 1));

	// Activity stretching; a new event reloads the timer
	assign raw_act = {tx_activity | rx_activity, rx_activity, tx_activity};
	for (genvar g = 0; g < 3; g++) begin : g_stretch
		logic [10:0] cnt_q;
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				cnt_q <= 11'd0;
			end else if (raw_act[g] && stretch_code != 3'b000) begin
				cnt_q <= LIOC_STRETCH_MS[stretch_code] + 11'd1;
			end else if (ms_tick && cnt_q != 11'd0) begin
				cnt_q <= cnt_q - 11'd1;
			end
		end
		assign str_act[g] = (stretch_code == 3'b000) ? raw_act[g] : (raw_act[g] | cnt_q != 11'd0);
	end

	// Blink phase toggles at the selected period; reserved codes stay defined
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blink_ms_q <= 10'd0;
			blink_q <= 1'b0;
		end else if (ms_tick) begin
			if (blink_ms_q >= LIOC_BLINK_MS[blink_code] - 10'd1) begin
				blink_ms_q <= 10'd0;
				blink_q <= ~blink_q;
			end else begin
				blink_ms_q <= blink_ms_q + 10'd1;
			end
		end
	end

	// Free running mix phase, eight steps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mix_ph_q <= 3'd0;
		end else begin
			mix_ph_q <= mix_ph_q + 3'd1;
		end
	end

	// Single pin function decode: stretched status, then blink
	function automatic logic [1:0] single_fn(input logic [3:0] code, input int pin);
		logic l;
		logic s10;
		logic s100;
		logic s1000;
		logic act_bl;
		logic [1:0] r;
		l = link_up;
		s10 = link_up && link_speed == LIOC_SPD_10;
		s100 = link_up && link_speed == LIOC_SPD_100;
		s1000 = link_up && link_speed == LIOC_SPD_1000;
		act_bl = str_act[2] & blink_q;
		r = 2'b00;
		case (code)
			LIOC_FN_SEL0: r = {1'b0, (pin == 1) ? str_act[1] : l};
			LIOC_FN_SEL1: r = {1'b0, l & (~str_act[2] | blink_q)};
			LIOC_FN_SEL2: begin
				if (pin == 2) r = {1'b0, (full_duplex & ~collision) | (collision & blink_q)};
				else if (pin == 1) r = {1'b0, l & (~str_act[1] | blink_q)};
				else r = {1'b0, l & blink_q};
			end
			LIOC_FN_SEL3: r = {1'b0, str_act[2]};
			LIOC_FN_SEL4: r = {1'b0, act_bl};
			LIOC_FN_SEL5: r = {1'b0, (pin == 1) ? (s100 | fiber_link) : str_act[0]};
			LIOC_FN_SEL6: begin
				if (pin == 2) r = {1'b0, s10 | s1000};
				else if (pin == 1) r = {1'b0, s100 | s1000};
				else r = {1'b0, l};
			end
			LIOC_FN_SEL7: r = {1'b0, (pin == 2) ? s10 : ((pin == 1) ? s100 : s1000)};
			LIOC_FN_OFF: r = 2'b00;
			LIOC_FN_ON: r = 2'b01;
			LIOC_FN_HIZ: r = 2'b10;
			LIOC_FN_BLINK: r = {1'b0, blink_q};
			default: r = 2'b00;
		endcase
		return r;
	endfunction

	// Paired unit: one status lit on the colour chosen by speed, or on both colours mixed at 10
	always_comb begin
		case (func_q[1:0])
			2'b00: unit_on = link_up;
			2'b01: unit_on = link_up & (~str_act[2] | blink_q);
			2'b10: unit_on = str_act[2];
			default: unit_on = str_act[2] & blink_q;
		endcase
	end

	// Per pin selection with mixing only in paired modes
	always_comb begin
		logic [1:0] f2;
		logic [1:0] f1;
		logic [1:0] f0;
		f2 = single_fn(func_q[LIOC_FN2_LSB +: 4], 2);
		f1 = single_fn(func_q[LIOC_FN1_LSB +: 4], 1);
		f0 = single_fn(func_q[LIOC_FN0_LSB +: 4], 0);
		lit_d[2] = f2[0];
		hiz_d[2] = f2[1];
		if (paired) begin
			hiz_d[1] = 1'b0;
			hiz_d[0] = 1'b0;
			case (link_speed)
				LIOC_SPD_1000: begin
					lit_d[0] = unit_on;
					lit_d[1] = 1'b0;
				end
				LIOC_SPD_100: begin
					lit_d[0] = 1'b0;
					lit_d[1] = unit_on;
				end
				default: begin
					lit_d[0] = unit_on & ({1'b0, mix_ph_q} < mix0);
					lit_d[1] = unit_on & ({1'b0, mix_ph_q} < mix1);
				end
			endcase
		end else begin
			lit_d[1] = f1[0];
			hiz_d[1] = f1[1];
			lit_d[0] = f0[0];
			hiz_d[0] = f0[1];
		end
	end

	// Last stage: polarity and tristate, pins one and zero released until configuration is done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out_q <= 3'b000;
			pin_oe_q <= 3'b000;
			lit_q <= 3'b000;
		end else begin
			lit_q <= lit_d;
			for (int i = 0; i < 3; i++) begin
				pin_out_q[i] <= lit_d[i] ? pol_q[2*i] : ~pol_q[2*i];
				pin_oe_q[i] <= ~hiz_d[i] & (lit_d[i] | ~pol_q[2*i+1]);
			end
			if (!config_done) begin
				pin_oe_q[1:0] <= 2'b00;
			end
		end
	end

	assign indicator_pin_zero_out = pin_out_q[0];
	assign indicator_pin_zero_oe = pin_oe_q[0];
	assign indicator_pin_one_out = pin_out_q[1];
	assign indicator_pin_one_oe = pin_oe_q[1];
	assign indicator_pin_two_out = pin_out_q[2];
	assign indicator_pin_two_oe = pin_oe_q[2];

	// Checks of the indicator path
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_strap_release;
		!config_done |=> !indicator_pin_zero_oe && !indicator_pin_one_oe;
	endproperty
	a_strap_release: assert property (p_strap_release) else $error("strap pins driven early");

	property p_pol_active;
		hresetn && lit_d[2] && !hiz_d[2] |=> indicator_pin_two_oe && indicator_pin_two_out == $past(pol_q[4]);
	endproperty
	a_pol_active: assert property (p_pol_active) else $error("active level wrong");

	property p_pol_idle;
		hresetn && !lit_d[2] && !hiz_d[2] |=> indicator_pin_two_oe == !$past(pol_q[5])
			&& (!indicator_pin_two_oe || indicator_pin_two_out == !$past(pol_q[4]));
	endproperty
	a_pol_idle: assert property (p_pol_idle) else $error("idle drive wrong");

	property p_force_codes;
		hresetn && func_q[11:8] == 4'b1001 |=> indicator_pin_two_oe && indicator_pin_two_out == $past(pol_q[4]);
	endproperty
	a_force_codes: assert property (p_force_codes) else $error("force on ignored");

	property p_force_hiz;
		func_q[11:8] == 4'b1010 |=> !indicator_pin_two_oe;
	endproperty
	a_force_hiz: assert property (p_force_hiz) else $error("force tristate ignored");

	property p_paired_speed;
		paired && func_q[1:0] == 2'b00 && link_up && link_speed == LIOC_SPD_100 |-> lit_d[1] && !lit_d[0];
	endproperty
	a_paired_speed: assert property (p_paired_speed) else $error("paired unit wrong");

	property p_mix_zero;
		paired && link_speed == LIOC_SPD_10 && mix0 == 4'h0 |-> !lit_d[0] ##1 1'b1;
	endproperty
	a_mix_zero: assert property (p_mix_zero) else $error("mix zero lit");

	property p_mix_full;
		paired && unit_on && link_speed == LIOC_SPD_10 && mix1 == LIOC_MIX_FULL |-> lit_d[1];
	endproperty
	a_mix_full: assert property (p_mix_full) else $error("full mix not lit");

	property p_static_pass;
		func_q[11:8] == 4'b0000 |-> lit_d[2] == link_up;
	endproperty
	a_static_pass: assert property (p_static_pass) else $error("static status altered");

	property p_no_stretch;
		stretch_code == 3'b000 |-> str_act == raw_act;
	endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("stretch when disabled");

	property p_stretch_hold;
		$fell(raw_act[2]) && stretch_code != 3'b000 && $stable(stretch_code) |-> str_act[2] [*8];
	endproperty
	a_stretch_hold: assert property (p_stretch_hold) else $error("stretch ended early");

	property p_blink_tick;
		$changed(blink_q) |-> $past(ms_tick);
	endproperty
	a_blink_tick: assert property (p_blink_tick) else $error("blink off time base");

	property p_blink_stretched;
		func_q[11:8] == 4'b0100 && lit_d[2] |-> str_act[2] && blink_q;
	endproperty
	a_blink_stretched: assert property (p_blink_stretched) else $error("blink not on stretch");

	property p_blink_bound;
		blink_ms_q <= 10'd670;
	endproperty
	a_blink_bound: assert property (p_blink_bound) else $error("blink count runaway");

	property p_order;
		$changed(lit_d[2]) && !hiz_d[2] && $stable(pol_q) |=> $changed(indicator_pin_two_out)
			|| $changed(indicator_pin_two_oe);
	endproperty
	a_order: assert property (p_order) else $error("polarity stage lag");

	c_config: cover property ($rose(config_done));
	c_retrigger: cover property (raw_act[2] ##1 !raw_act[2] ##3 raw_act[2]);
	c_mix: cover property (paired && link_speed == LIOC_SPD_10 && lit_d[0] ##1 !lit_d[0]);
	c_blink: cover property ($rose(blink_q));
endmodule

/* test/lioc_led_model.sv */
// External indicator lamp with a strap resistor on its pin
`timescale 1ns/100ps
module lioc_led_model #(
	parameter logic PULL = 1'b0
) (
	input wire logic drv,
	input wire logic en,
	output logic lvl
);
	// Released pin falls back to the strap resistor level, never the last driven value
	assign lvl = en ? drv : PULL;
endmodule

/* test/tb_top.sv */
// Self-checking testbench of the indicator output control block
`timescale 1ns/100ps
module tb_top import lioc_pkg::*;;
	localparam int MSC = 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic link_up = 1'b1;
	logic collision = 1'b0;
	logic tx_activity = 1'b0;
	logic rx_activity = 1'b0;
	logic config_done = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rdat;
	logic [1:0] htrans = 2'h0;
	logic [1:0] link_speed = 2'h2;
	wire hready;
	wire hresp;
	wire [31:0] hrdata;
	wire z_o, z_e, o_o, o_e, t_o, t_e, z_p, o_p;
	wire [5:0] pv = {t_o, t_e, o_o, o_e, z_o, z_e};
	int error_cnt = 0;
	int comparisons = 0;
	int sms[8] = '{0, 21, 42, 84, 170, 340, 670, 1300};
	int bms[8] = '{42, 84, 170, 340, 670, 670, 670, 670};

	// Clock at 40 ns
	always #20 hclk = ~hclk;

	lioc_indicator_ctrl #(.MS_CYCLES(MSC)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hrdata(hrdata), .hresp(hresp), .link_up(link_up), .link_speed(link_speed), .fiber_link(1'b0),
		.full_duplex(1'b1), .collision(collision), .tx_activity(tx_activity), .rx_activity(rx_activity),
		.config_done(config_done), .indicator_pin_zero_in(z_p), .indicator_pin_zero_out(z_o),
		.indicator_pin_zero_oe(z_e), .indicator_pin_one_in(o_p), .indicator_pin_one_out(o_o),
		.indicator_pin_one_oe(o_e), .indicator_pin_two_out(t_o), .indicator_pin_two_oe(t_e));
	lioc_led_model #(.PULL(1'b0)) u_led0 (.drv(z_o), .en(z_e), .lvl(z_p));
	lioc_led_model #(.PULL(1'b1)) u_led1 (.drv(o_o), .en(o_e), .lvl(o_p));

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Value compare
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Count compare against a window
	task automatic rng(input int n, input int lo, input int hi);
		comparisons++;
		if (n < lo || n > hi) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h..%h", $time, n, lo, hi);
		end
	endtask

	// Bounded wait for hready at a rising edge
	task automatic wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hready !== 1'b1 && i < 50);
		if (hready !== 1'b1) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask

	// One single-word bus transfer, read data left in rdat
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= LIOC_HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rdat = hrdata;
	endtask

	// Register write, then let the pins settle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, {16'h0000, d});
		repeat (3) @(posedge hclk);
	endtask

	// One-cycle activity pulse
	task automatic pulse(input bit rx);
		@(posedge hclk);
		if (rx) begin
			rx_activity <= 1'b1;
		end else begin
			tx_activity <= 1'b1;
		end
		@(posedge hclk);
		tx_activity <= 1'b0;
		rx_activity <= 1'b0;
	endtask

	// Cycles that pin two stays lit
	task automatic lit_len(output int n);
		int w;
		n = 0;
		w = 0;
		while (t_o !== 1'b1 && w < 4) begin
			@(posedge hclk);
			w++;
		end
		while (t_o === 1'b1 && n < 6000) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 6000) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask

	// Cycles until pin two changes level
	task automatic gap(output int n);
		logic v;
		v = t_o;
		n = 0;
		while (t_o === v && n < 6000) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 6000) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask

	// Pins zero and one stay released while straps are sampled
	task automatic t_straps;
		repeat (3) @(posedge hclk);
		chk({30'h0, o_e, z_e}, 32'h0);
		bus(1'b0, LIOC_OFS_STAT, 32'h0);
		chk({29'h0, rdat[2:0]}, 32'h4);
	endtask

	// Reset values, unmapped place and read back
	task automatic t_regs;
		bus(1'b0, LIOC_OFS_FUNC, 32'h0);
		chk(rdat, {16'h0000, LIOC_FUNC_RST});
		chk({31'h0, hresp}, 32'h0);
		bus(1'b0, LIOC_OFS_POL, 32'h0);
		chk(rdat, {16'h0000, LIOC_POL_RST});
		bus(1'b0, LIOC_OFS_TIM, 32'h0);
		chk(rdat, {16'h0000, LIOC_TIM_RST});
		bus(1'b1, 8'h10, 32'hFFFFFFFF);
		bus(1'b0, 8'h10, 32'h0);
		chk(rdat, 32'h0);
		bus(1'b1, LIOC_OFS_FUNC, 32'h12340A98);
		bus(1'b0, LIOC_OFS_FUNC, 32'h0);
		chk(rdat, 32'h00000A98);
	endtask

	// Every polarity code against forced off, on and tristate
	task automatic t_pol;
		logic [1:0] e;
		logic [1:0] m;
		for (int p = 0; p < 4; p++) begin
			for (int f = 8; f < 11; f++) begin
				wr(LIOC_OFS_POL, {10'h0, {3{p[1:0]}}});
				wr(LIOC_OFS_FUNC, {4'h0, f[3:0], f[3:0], f[3:0]});
				e = {(f == 9) ? p[0] : ~p[0], (f != 10) && (f == 9 || !p[1])};
				m = {e[0], 1'b1};
				chk({26'h0, pv & {3{m}}}, {26'h0, {3{e & m}}});
			end
		end
		wr(LIOC_OFS_POL, 16'h0015);
		wr(LIOC_OFS_FUNC, 16'h0989);
		chk({26'h0, pv}, 32'h37);
	endtask

	// Stretch lengths, retrigger, no stretch and static status
	task automatic t_stretch;
		int n;
		wr(LIOC_OFS_FUNC, 16'h0388);
		for (int c = 1; c < 8; c++) begin
			wr(LIOC_OFS_TIM, 16'(c << 12));
			pulse(0);
			lit_len(n);
			rng(n, sms[c] * MSC, (sms[c] + 1) * MSC + 6);
		end
		wr(LIOC_OFS_TIM, 16'h1000);
		pulse(1);
		repeat (40) @(posedge hclk);
		pulse(1);
		lit_len(n);
		rng(n, 84, 94);
		wr(LIOC_OFS_TIM, 16'h0000);
		pulse(0);
		lit_len(n);
		rng(n, 1, 3);
		wr(LIOC_OFS_TIM, 16'h7000);
		wr(LIOC_OFS_FUNC, 16'h0088);
		link_up <= 1'b0;
		lit_len(n);
		rng(n, 0, 3);
		link_up <= 1'b1;
	endtask

	// Blinking goes on for 400 cycles inside the stretched pulse
	task automatic t_r9;
		int n;
		wr(LIOC_OFS_FUNC, 16'h0488);
		wr(LIOC_OFS_TIM, 16'h4000);
		pulse(0);
		repeat (200) @(posedge hclk);
		n = 0;
		repeat (400) begin
			@(posedge hclk);
			n += (t_o === 1'b1);
		end
		rng(n, 160, 240);
	endtask

	// Blink half period for every rate code
	task automatic t_blink;
		int n;
		wr(LIOC_OFS_FUNC, 16'h0B88);
		for (int c = 0; c < 8; c++) begin
			wr(LIOC_OFS_TIM, 16'(c << 8));
			gap(n);
			gap(n);
			gap(n);
			rng(n, bms[c] * MSC - 5, bms[c] * MSC + 5);
		end
	endtask

	// Paired mode, ignored pin one field, speed colours and mixing
	task automatic t_pair;
		int n;
		wr(LIOC_OFS_POL, 16'h8805);
		wr(LIOC_OFS_FUNC, 16'h099C);
		chk({26'h0, pv}, 32'h17);
		link_speed <= 2'h1;
		repeat (3) @(posedge hclk);
		chk({26'h0, pv}, 32'h1D);
		link_speed <= 2'h0;
		for (int k = 0; k < 2; k++) begin
			wr(LIOC_OFS_POL, 16'(32'h8005 | (k << 10)));
			n = 0;
			repeat (16) begin
				@(posedge hclk);
				n += (z_o === 1'b1);
			end
			rng(n, 8 * k, 8 * k);
		end
	endtask

	// Speed and transmit codes on single pins
	task automatic t_codes;
		wr(LIOC_OFS_POL, 16'h0015);
		wr(LIOC_OFS_FUNC, 16'h0765);
		link_speed <= 2'h0;
		repeat (3) @(posedge hclk);
		chk({26'h0, pv}, 32'h35);
		link_speed <= 2'h2;
		tx_activity <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({26'h0, pv}, 32'h1F);
		tx_activity <= 1'b0;
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_straps();
		config_done <= 1'b1;
		t_regs();
		t_pol();
		t_stretch();
		t_r9();
		t_blink();
		t_pair();
		t_codes();
		tally_and_finish();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge hclk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
